// >>> verilog/erx_rx_mac.sv
`timescale 1ns/100ps
`include "erx_map.svh"
module erx_rx_mac import erx_pkg::*; #(
  parameter int MAX_FRAME_DEF = `ERX_MAXLEN_RST
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Decoded MII, one lane byte per clock
  input wire logic [7:0] mii_data_i,
  input wire logic mii_ctrl_i,
  // Packet-style client stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_sop_o,
  output logic rx_eop_o,
  output logic [4:0] rx_error_o,
  // Segmented end-of-packet status
  output logic seg_eop_o,
  output logic [1:0] seg_error_o,
  output logic seg_fcs_error_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);
  // Length counters are 16 bits wide; a limit under 64 would cut every frame
  if (MAX_FRAME_DEF < 64 || MAX_FRAME_DEF > 65535) begin : g_bad_max
    $error("MAX_FRAME_DEF out of range");
  end

  erx_s_t s_reg;
  erx_s_t s_next;
  logic crc_init;
  logic crc_en;
  logic crc_ok;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction : reg_hit

  erx_crc32 u_crc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .init_i(crc_init),
    .en_i(crc_en),
    .data_i(mii_data_i),
    .ok_o(crc_ok)
  );

  // --------------------------------------------------------------------------
  // Frame state machine, output beat and register file
  // --------------------------------------------------------------------------
  always_comb begin
    logic pt;
    logic spre;
    logic ssfd;
    logic enf;
    erx_strip_t mode;
    logic start_hit;
    logic cand_v;
    logic [7:0] cand_d;
    logic tail;
    logic mal_end;
    logic bad;
    logic under;
    logic over;
    logic size_e;
    logic fcs_e;
    logic len_e;
    logic mal;
    logic [4:0] err;
    s_next = s_reg;
    pt = s_reg.ctrl[`ERX_CTRL_PT];
    spre = s_reg.ctrl[`ERX_CTRL_SPRE];
    ssfd = s_reg.ctrl[`ERX_CTRL_SSFD];
    enf = s_reg.ctrl[`ERX_CTRL_ENF];
    mode = erx_strip_t'(s_reg.ctrl[`ERX_CTRL_STRIP_LO +: 2]);
    start_hit = mii_ctrl_i && (mii_data_i == `ERX_CH_START) && (s_reg.lane == 3'h0);
    cand_v = 1'b0;
    cand_d = 8'h00;
    tail = 1'b0;
    mal_end = 1'b0;
    bad = 1'b0;
    crc_init = 1'b0;
    crc_en = 1'b0;
    s_next.lane = s_reg.lane + 3'h1;
    s_next.o_v = 1'b0;
    s_next.o_d = 8'h00;
    s_next.o_sop = 1'b0;
    s_next.o_eop = 1'b0;
    s_next.o_err = 5'h00;
    s_next.o_seg_eop = 1'b0;
    s_next.o_seg_err = 2'h0;
    s_next.o_seg_fcs = 1'b0;
    case (s_reg.st)
      ERX_IDLE: begin
        // Idle and gap bytes fall through here unforwarded
        if (start_hit) begin
          s_next.st = ERX_PRE;
          s_next.pcnt = 3'h0;
          s_next.lead_bad = 1'b0;
          s_next.first = 1'b1;
          s_next.pend_v = 1'b0;
          s_next.dcnt = 3'h0;
          s_next.flen = 16'h0000;
          s_next.oidx = 16'h0000;
          s_next.ltype = 16'hffff;
          s_next.err_ctrl = 1'b0;
          s_next.trunc = 1'b0;
          if (pt) begin
            cand_v = 1'b1;
            cand_d = mii_data_i;
          end
        end
      end
      ERX_PRE: begin
        s_next.pcnt = s_reg.pcnt + 3'h1;
        if (mii_ctrl_i) begin
          // Lead-in cut short: a passthrough frame is already open and must close
          s_next.st = ERX_IDLE;
          if (pt) begin
            tail = 1'b1;
            mal_end = 1'b1;
          end else begin
            s_next.drop_cnt = s_reg.drop_cnt + 32'h1;
          end
        end else begin
          if (pt) begin
            cand_v = 1'b1;
            cand_d = mii_data_i;
          end
          if (s_reg.pcnt != `ERX_PRE_LAST && spre && mii_data_i != `ERX_PREAMBLE) begin
            s_next.lead_bad = 1'b1;
          end
          if (s_reg.pcnt == `ERX_PRE_LAST) begin
            crc_init = 1'b1;
            bad = s_reg.lead_bad || (ssfd && mii_data_i != `ERX_SFD);
            s_next.lead_bad = bad;
            if (bad && !pt) begin
              s_next.st = ERX_DROP;
              s_next.close = 1'b0;
              s_next.drop_cnt = s_reg.drop_cnt + 32'h1;
            end else begin
              s_next.st = ERX_DATA;
            end
          end
        end
      end
      ERX_DATA: begin
        if (!mii_ctrl_i) begin
          crc_en = 1'b1;
          s_next.flen = s_reg.flen + 16'h1;
          if (s_reg.flen == `ERX_LT_HI_IDX) begin
            s_next.ltype[15:8] = mii_data_i;
          end
          if (s_reg.flen == `ERX_LT_LO_IDX) begin
            s_next.ltype[7:0] = mii_data_i;
          end
          // Four-byte hold-back lets the checksum be dropped without lookahead
          if (mode == ERX_KEEP_ALL) begin
            cand_v = 1'b1;
            cand_d = mii_data_i;
          end else begin
            s_next.dl = {s_reg.dl[2:0], mii_data_i};
            if (s_reg.dcnt == `ERX_DELAY_DEPTH) begin
              cand_v = 1'b1;
              cand_d = s_reg.dl[3];
            end else begin
              s_next.dcnt = s_reg.dcnt + 3'h1;
            end
          end
          if (cand_v) begin
            s_next.oidx = s_reg.oidx + 16'h1;
          end
          if (cand_v && mode[1] && s_reg.ltype <= `ERX_MAX_LENFIELD &&
              s_reg.oidx >= `ERX_HDR_BYTES + s_reg.ltype) begin
            cand_v = 1'b0;
          end
          if (enf && s_next.flen == s_reg.maxlen) begin
            s_next.trunc = 1'b1;
            s_next.st = ERX_DROP;
            s_next.close = 1'b1;
          end
        end else if (mii_data_i == `ERX_CH_ERROR) begin
          s_next.err_ctrl = 1'b1;
        end else begin
          tail = 1'b1;
          mal_end = (mii_data_i != `ERX_CH_TERM);
          s_next.st = ERX_IDLE;
        end
      end
      default: begin
        // Discard the rest of a rejected or truncated frame
        tail = s_reg.close;
        s_next.close = 1'b0;
        if (mii_ctrl_i && mii_data_i != `ERX_CH_ERROR) begin
          s_next.st = ERX_IDLE;
        end
      end
    endcase
    // A byte is only sent once its successor or the frame end is known
    if (cand_v) begin
      if (s_reg.pend_v) begin
        s_next.o_v = 1'b1;
        s_next.o_d = s_reg.pend_d;
        s_next.o_sop = s_reg.pend_sop;
      end
      s_next.pend_v = 1'b1;
      s_next.pend_d = cand_d;
      s_next.pend_sop = s_next.first;
      s_next.first = 1'b0;
    end
    under = s_reg.flen < `ERX_MIN_FRAME;
    over = s_reg.flen > s_reg.maxlen;
    size_e = under || over || s_reg.trunc;
    fcs_e = (!under && !crc_ok) || s_reg.err_ctrl || s_reg.trunc;
    len_e = (s_reg.ltype <= `ERX_MAX_LENFIELD) &&
            ({1'b0, s_reg.ltype} + `ERX_HDR_FCS_BYTES > {1'b0, s_reg.flen});
    mal = mal_end || s_reg.lead_bad;
    err = {len_e, 1'b0, size_e, fcs_e, mal};
    if (tail) begin
      s_next.o_v = 1'b1;
      s_next.o_d = s_reg.pend_d;
      s_next.o_sop = s_reg.pend_v ? s_reg.pend_sop : 1'b1;
      s_next.o_eop = 1'b1;
      s_next.o_err = err;
      s_next.o_seg_eop = 1'b1;
      s_next.o_seg_fcs = fcs_e;
      if (mal) begin
        s_next.o_seg_err = 2'h1;
      end else if (size_e) begin
        s_next.o_seg_err = 2'h2;
      end else if (len_e) begin
        s_next.o_seg_err = 2'h3;
      end
      s_next.pend_v = 1'b0;
      s_next.last_err = err;
      if (err == 5'h00) begin
        s_next.good_cnt = s_reg.good_cnt + 32'h1;
      end
    end
    // Bus data phase: mode bits take effect at once, so change them between frames
    if (s_reg.w_pend) begin
      if (reg_hit(s_reg.w_addr, `ERX_OFF_CTRL)) begin
        s_next.ctrl = hwdata_i[5:0];
      end else if (reg_hit(s_reg.w_addr, `ERX_OFF_MAXLEN)) begin
        s_next.maxlen = hwdata_i[15:0];
      end
    end
    s_next.w_pend = 1'b0;
    // Bus address phase; reads see a write finishing in the same cycle
    if (hsel_i && hready_i && htrans_i[1]) begin
      if (hwrite_i) begin
        s_next.w_pend = 1'b1;
        s_next.w_addr = haddr_i[7:0];
      end else if (reg_hit(haddr_i[7:0], `ERX_OFF_CTRL)) begin
        s_next.rdata = {26'h0, s_next.ctrl};
      end else if (reg_hit(haddr_i[7:0], `ERX_OFF_MAXLEN)) begin
        s_next.rdata = {16'h0, s_next.maxlen};
      end else if (reg_hit(haddr_i[7:0], `ERX_OFF_STATUS)) begin
        s_next.rdata = {19'h0, s_next.last_err, 6'h0, s_reg.st};
      end else if (reg_hit(haddr_i[7:0], `ERX_OFF_GOOD)) begin
        s_next.rdata = s_next.good_cnt;
      end else if (reg_hit(haddr_i[7:0], `ERX_OFF_DROP)) begin
        s_next.rdata = s_next.drop_cnt;
      end else begin
        s_next.rdata = 32'h0;
      end
    end
    s_next.ready = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.ctrl <= `ERX_CTRL_RST;
      s_reg.maxlen <= 16'(MAX_FRAME_DEF);
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rx_valid_o = s_reg.o_v;
  assign rx_data_o = s_reg.o_d;
  assign rx_sop_o = s_reg.o_sop;
  assign rx_eop_o = s_reg.o_eop;
  assign rx_error_o = s_reg.o_err;
  assign seg_eop_o = s_reg.o_seg_eop;
  assign seg_error_o = s_reg.o_seg_err;
  assign seg_fcs_error_o = s_reg.o_seg_fcs;
  assign hreadyout_o = s_reg.ready;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_reg.rdata;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence start_seen;
    s_reg.st == ERX_IDLE && mii_ctrl_i && mii_data_i == `ERX_CH_START && s_reg.lane == 3'h0;
  endsequence

  sequence trunc_hit;
    s_reg.st == ERX_DATA && s_reg.ctrl[`ERX_CTRL_ENF] && !mii_ctrl_i &&
      (s_reg.flen + 16'h1 == s_reg.maxlen);
  endsequence

  sequence bad_end;
    s_reg.st == ERX_DATA && mii_ctrl_i && mii_data_i != `ERX_CH_TERM &&
      mii_data_i != `ERX_CH_ERROR;
  endsequence

  a_start_lane0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_seen |=> s_reg.st == ERX_PRE)
    else $error("start on lane 0 not taken");

  a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_IDLE && !(mii_ctrl_i && mii_data_i == `ERX_CH_START)) |=>
      s_reg.st == ERX_IDLE)
    else $error("frame opened without start byte");

  a_gap_silent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_IDLE && !mii_ctrl_i) |=> !rx_valid_o)
    else $error("gap byte forwarded");

  a_leadin_hidden: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_PRE && !s_reg.ctrl[`ERX_CTRL_PT]) |=> !rx_valid_o)
    else $error("lead-in byte forwarded");

  a_sfd_strict: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_PRE && s_reg.pcnt == `ERX_PRE_LAST && !mii_ctrl_i &&
     s_reg.ctrl[`ERX_CTRL_SSFD] && !s_reg.ctrl[`ERX_CTRL_PT] && mii_data_i != `ERX_SFD)
      |=> s_reg.st == ERX_DROP ##1 !rx_valid_o)
    else $error("bad delimiter accepted");

  a_pre_strict: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_PRE && s_reg.pcnt < `ERX_PRE_LAST && !mii_ctrl_i &&
     s_reg.ctrl[`ERX_CTRL_SPRE] && mii_data_i != `ERX_PREAMBLE) |=> s_reg.lead_bad)
    else $error("bad preamble byte missed");

  a_trunc_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trunc_hit |-> ##2 (rx_eop_o && rx_error_o[2] && rx_error_o[1] && seg_fcs_error_o))
    else $error("truncation not flagged");

  a_malformed_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bad_end |=> (rx_eop_o && rx_error_o[0] && seg_error_o == 2'h1))
    else $error("malformed end not flagged");

  a_eop_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_eop_o || seg_eop_o) |-> (rx_valid_o && rx_eop_o && seg_eop_o &&
      seg_fcs_error_o == rx_error_o[1]))
    else $error("end status split from end beat");

  a_back_to_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == ERX_DATA && mii_ctrl_i && mii_data_i == `ERX_CH_TERM) |=>
      s_reg.st == ERX_IDLE)
    else $error("not ready for next frame");
endmodule : erx_rx_mac

// >>> pkg/erx_map.svh
// Overview of operation
// - A frame opens with Start on MII lane 0, six preamble bytes, then the delimiter.
// - Start is found as control byte 0xFB with its control flag set.
// - Without passthrough, Start, preamble, delimiter and idle bytes never reach the client.
// - With passthrough, the eight lead-in bytes stay at the front of each frame.
// - Every incoming packet must open with the Start character 0xFB.
// - Strict preamble checking drops frames whose preamble bytes are not all 0x55; with passthrough they are forwarded flagged malformed.
// - Strict delimiter checking drops frames whose delimiter byte is not 0xD5; with passthrough they are forwarded flagged malformed.
// - Frames of minimum size or more get checksum checked; mismatch raises error bit 1.
// - On the segmented outputs a checksum mismatch raises the checksum error output.
// - A frame carrying an Error control byte is reported as a checksum error.
// - A frame ending on a control byte other than Terminate is malformed: bit 0, code 1.
// - Frames under 64 bytes are undersized, unchecked for checksum: bit 2, code 2.
// - Frames over the maximum frame size are oversized at frame end: bit 2, code 2.
// - With enforcement, frames end on reaching maximum size with error bits 2 and 1.
// - Length/Type at most 1500 larger than received length gives bit 4, code 3.
// - Trailing bytes are kept, checksum stripped, or checksum and pad stripped, per setting.
// - Inter-packet gap octets are discarded and never forwarded to the client.
// - Back-to-back frames with a gap down to one byte are sustained.
// - Frames go to the client with framing markers and their check results.
`ifndef ERX_MAP_SVH
`define ERX_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ERX_OFF_CTRL 8'h00
`define ERX_OFF_MAXLEN 8'h04
`define ERX_OFF_STATUS 8'h08
`define ERX_OFF_GOOD 8'h0c
`define ERX_OFF_DROP 8'h10
// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define ERX_CTRL_PT 0
`define ERX_CTRL_SPRE 1
`define ERX_CTRL_SSFD 2
`define ERX_CTRL_ENF 3
`define ERX_CTRL_STRIP_LO 4
`define ERX_CTRL_RST 6'h10
`define ERX_MAXLEN_RST 1518
`define ERX_STAT_ERR_LO 8
// ----------------------------------------------------------------------------
// Byte codes, sizes and checksum constants
// ----------------------------------------------------------------------------
`define ERX_CH_START 8'hfb
`define ERX_CH_TERM 8'hfd
`define ERX_CH_ERROR 8'hfe
`define ERX_PREAMBLE 8'h55
`define ERX_SFD 8'hd5
`define ERX_PRE_LAST 3'h6
`define ERX_MIN_FRAME 16'h0040
`define ERX_MAX_LENFIELD 16'h05dc
`define ERX_HDR_BYTES 16'h000e
`define ERX_HDR_FCS_BYTES 17'h00012
`define ERX_LT_HI_IDX 16'h000c
`define ERX_LT_LO_IDX 16'h000d
`define ERX_DELAY_DEPTH 3'h4
`define ERX_CRC_POLY 32'hedb88320
`define ERX_CRC_INIT 32'hffffffff
`define ERX_CRC_RESIDUE 32'hdebb20e3
`endif

// >>> pkg/erx_pkg.sv
package erx_pkg;
  // Gray order along idle -> lead-in -> data -> drop
  typedef enum logic [1:0] {
    ERX_IDLE = 2'b00,
    ERX_PRE = 2'b01,
    ERX_DATA = 2'b11,
    ERX_DROP = 2'b10
  } erx_state_t;

  typedef enum logic [1:0] {
    ERX_KEEP_ALL = 2'b00,
    ERX_STRIP_FCS = 2'b01,
    ERX_STRIP_PAD = 2'b10,
    ERX_STRIP_PAD2 = 2'b11
  } erx_strip_t;

  typedef struct packed {
    logic [31:0] crc;
  } erx_crc_s_t;

  typedef struct packed {
    erx_state_t st;
    logic [2:0] lane;
    logic [2:0] pcnt;
    logic lead_bad;
    logic [15:0] flen;
    logic [15:0] oidx;
    logic [15:0] ltype;
    logic [3:0][7:0] dl;
    logic [2:0] dcnt;
    logic pend_v;
    logic [7:0] pend_d;
    logic pend_sop;
    logic first;
    logic err_ctrl;
    logic trunc;
    logic close;
    logic o_v;
    logic [7:0] o_d;
    logic o_sop;
    logic o_eop;
    logic [4:0] o_err;
    logic o_seg_eop;
    logic [1:0] o_seg_err;
    logic o_seg_fcs;
    logic [5:0] ctrl;
    logic [15:0] maxlen;
    logic [31:0] good_cnt;
    logic [31:0] drop_cnt;
    logic [4:0] last_err;
    logic w_pend;
    logic [7:0] w_addr;
    logic [31:0] rdata;
    logic ready;
  } erx_s_t;
endpackage : erx_pkg

// >>> verilog/erx_crc32.sv
`timescale 1ns/100ps
`include "erx_map.svh"
module erx_crc32 import erx_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Byte stream
  input wire logic init_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  // Residue match
  output logic ok_o
);
  erx_crc_s_t s_reg;
  erx_crc_s_t s_next;

  // --------------------------------------------------------------------------
  // Reflected CRC-32, one byte per clock, lsb first
  // --------------------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    c = s_reg.crc;
    s_next = s_reg;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data_i[i]) begin
        c = (c >> 1) ^ `ERX_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    if (init_i) begin
      s_next.crc = `ERX_CRC_INIT;
    end else if (en_i) begin
      s_next.crc = c;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg.crc <= `ERX_CRC_INIT;
    end else begin
      s_reg <= s_next;
    end
  end

  // Running over data and checksum leaves the fixed residue on a good frame
  assign ok_o = (s_reg.crc == `ERX_CRC_RESIDUE);
endmodule : erx_crc32

// >>> verification/erx_client_model.sv
`timescale 1ns/100ps
module erx_client_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Packet-style stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  input wire logic [4:0] rx_error_i,
  // Segmented end-of-packet status
  input wire logic seg_eop_i,
  input wire logic [1:0] seg_error_i,
  input wire logic seg_fcs_error_i
);
  // --------------------
  // Sink state
  // --------------------
  // Always ready: the receiver has no stall input, so no slow mode exists
  logic [7:0] q[$];
  logic [4:0] err;
  logic [1:0] serr;
  logic sfcs;
  logic mid = 1'b0;
  int nfr = 0;
  int bad = 0;
  always @(posedge clk_i) begin
    if (rst_n_i && rx_valid_i === 1'b1) begin
      if (rx_sop_i !== !mid) bad++;
      mid = !rx_eop_i;
      q.push_back(rx_data_i);
    end
    if (rst_n_i && (rx_eop_i === 1'b1 || seg_eop_i === 1'b1)) begin
      if (rx_eop_i !== 1'b1 || seg_eop_i !== 1'b1 || rx_valid_i !== 1'b1) bad++;
      err = rx_error_i;
      serr = seg_error_i;
      sfcs = seg_fcs_error_i;
      nfr++;
    end
    else if (rst_n_i && (rx_error_i !== 5'h00 || seg_error_i !== 2'h0)) bad++;
  end
endmodule : erx_client_model

// >>> verification/ethernet_rx_mac_frame_checker_bench.sv
`timescale 1ns/100ps
module ethernet_rx_mac_frame_checker_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] mii = 9'h107;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hrdy, hresp, v, sop, eop, seop, sfcs;
  logic [31:0] hrdata;
  logic [7:0] d8;
  logic [4:0] e5;
  logic [1:0] s2;
  logic [7:0] f[$];
  logic [8:0] w[$];
  int cyc, err_count = 0, n_tests = 0;
  erx_rx_mac u_erx_rx_mac (.clk_i(clk), .rst_n_i(rst_n), .mii_data_i(mii[7:0]),
    .mii_ctrl_i(mii[8]), .rx_valid_o(v), .rx_data_o(d8), .rx_sop_o(sop), .rx_eop_o(eop),
    .rx_error_o(e5), .seg_eop_o(seop), .seg_error_o(s2), .seg_fcs_error_o(sfcs),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
    .hresp_o(hresp), .hrdata_o(hrdata));
  erx_client_model u_erx_client_model (.clk_i(clk), .rst_n_i(rst_n), .rx_valid_i(v),
    .rx_data_i(d8), .rx_sop_i(sop), .rx_eop_i(eop), .rx_error_i(e5), .seg_eop_i(seop),
    .seg_error_i(s2), .seg_fcs_error_i(sfcs));
  always #5 clk = ~clk;
  // Counts edges since release; a byte driven now is sampled on lane (cyc + 1) % 8
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end
  // --------------------
  // Helpers
  // --------------------
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (hrdy !== 1'b1 && k < 20);
      if (hrdy !== 1'b1) begin
        err_count++;
        end_of_test();
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
    end
    r = hrdata;
    ck(hresp, 1'b0);
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    ck(r, e);
  endtask : rd
  // Frame of n bytes DA..FCS; FCS sent low byte first, optionally spoilt
  function automatic void mk(input int n, input logic [15:0] lt, input logic bad);
    logic [31:0] c;
    c = 32'hffffffff;
    f = {};
    for (int i = 0; i < n - 4; i++) begin
      f.push_back(i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i * 7 + 3));
      c = c ^ {24'h0, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) f.push_back(c[8 * i +: 8]);
    w = {9'h1fb, 9'h055, 9'h055, 9'h055, 9'h055, 9'h055, 9'h055, 9'h0d5};
    foreach (f[i]) w.push_back({1'b0, f[i]});
    w.push_back(9'h1fd);
  endfunction : mk
  task automatic go(input int nexp, input int skew = 0);
    int n0, k;
    n0 = u_erx_client_model.nfr;
    u_erx_client_model.q = {};
    @(posedge clk);
    while ((cyc + 1) % 8 != skew) @(posedge clk);
    foreach (w[i]) begin
      mii <= w[i];
      @(posedge clk);
    end
    mii <= 9'h107;
    for (k = 0; k < 60 && u_erx_client_model.nfr < n0 + nexp; k++) @(posedge clk);
    if (k == 60) begin
      err_count++;
      end_of_test();
    end
    repeat (8) @(posedge clk);
    ck(u_erx_client_model.nfr - n0, nexp);
  endtask : go
  task automatic run(input logic [4:0] ee, input logic [1:0] es);
    go(1);
    ck(u_erx_client_model.err, ee);
    ck(u_erx_client_model.serr, es);
    ck(u_erx_client_model.sfcs, ee[1]);
  endtask : run
  task automatic cq(input logic [7:0] e[$]);
    ck(u_erx_client_model.q.size(), e.size());
    foreach (e[i]) ck(u_erx_client_model.q[i], e[i]);
  endtask : cq
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs();
    rd(32'h00, 32'h10);
    rd(32'h04, 32'd1518);
    wr(32'h08, 32'hffff);
    rd(32'h08, 32'h0);
    rd(32'h40, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_good();
    mk(64, 16'h0800, 1'b0);
    run(5'h00, 2'h0);
    cq(f[0:59]);
    rd(32'h0c, 32'h1);
    $display("t_good done");
  endtask : t_good
  task automatic t_fcs();
    mk(64, 16'h0800, 1'b1);
    run(5'h02, 2'h0);
    mk(64, 16'h0800, 1'b0);
    w.insert(30, 9'h1fe);
    run(5'h02, 2'h0);
    $display("t_fcs done");
  endtask : t_fcs
  task automatic t_malformed();
    mk(64, 16'h0800, 1'b0);
    w[w.size() - 1] = 9'h19c;
    run(5'h01, 2'h1);
    $display("t_malformed done");
  endtask : t_malformed
  task automatic t_runt();
    mk(60, 16'h0800, 1'b1);
    run(5'h04, 2'h2);
    $display("t_runt done");
  endtask : t_runt
  task automatic t_len();
    mk(64, 16'd100, 1'b0);
    run(5'h10, 2'h3);
    rd(32'h08, 32'h1000);
    $display("t_len done");
  endtask : t_len
  task automatic t_size();
    wr(32'h04, 32'd100);
    mk(100, 16'h0800, 1'b0);
    run(5'h00, 2'h0);
    mk(101, 16'h0800, 1'b0);
    run(5'h04, 2'h2);
    wr(32'h00, 32'h18);
    mk(110, 16'h0800, 1'b0);
    run(5'h06, 2'h2);
    wr(32'h00, 32'h10);
    wr(32'h04, 32'd1518);
    $display("t_size done");
  endtask : t_size
  task automatic t_modes();
    mk(64, 16'd20, 1'b0);
    wr(32'h00, 32'h11);
    run(5'h00, 2'h0);
    cq({8'hfb, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hd5, f[0:59]});
    wr(32'h00, 32'h00);
    run(5'h00, 2'h0);
    cq(f);
    wr(32'h00, 32'h20);
    run(5'h00, 2'h0);
    cq(f[0:33]);
    wr(32'h00, 32'h10);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_strict();
    mk(64, 16'h0800, 1'b0);
    wr(32'h00, 32'h12);
    w[3] = 9'h054;
    go(0);
    rd(32'h10, 32'h1);
    wr(32'h00, 32'h14);
    w[3] = 9'h055;
    w[7] = 9'h0d4;
    go(0);
    rd(32'h10, 32'h2);
    wr(32'h00, 32'h10);
    run(5'h00, 2'h0);
    cq(f[0:59]);
    $display("t_strict done");
  endtask : t_strict
  task automatic t_lane();
    mk(64, 16'h0800, 1'b0);
    go(0, 3);
    w[0] = 9'h0fb;
    go(0);
    $display("t_lane done");
  endtask : t_lane
  task automatic t_b2b();
    mk(71, 16'h0800, 1'b0);
    w = {w, w};
    go(2);
    cq({f[0:66], f[0:66]});
    $display("t_b2b done");
  endtask : t_b2b
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_good();
    t_fcs();
    t_malformed();
    t_runt();
    t_len();
    t_size();
    t_modes();
    t_strict();
    t_lane();
    t_b2b();
    ck(u_erx_client_model.bad, 0);
    end_of_test();
  end
endmodule : ethernet_rx_mac_frame_checker_bench
